// ---- verilog/dual_synth_mode_powerdown_ctrl.sv ----
// Top of the dual synthesizer mode and powerdown control
`timescale 1ns/1ps
`default_nettype none
module dual_synth_mode_powerdown_ctrl (
  input  wire logic  core_clk_in,
  input  wire logic  rst_n_in,
  input  wire logic  serial_clock_in,
  input  wire logic  serial_data_in,
  input  wire logic  latch_strobe_in,
  input  wire logic  loop_one_locked_in,
  input  wire logic  loop_two_locked_in,
  input  wire logic  loop_one_ref_div_in,
  input  wire logic  loop_two_ref_div_in,
  input  wire logic  loop_one_fb_div_in,
  input  wire logic  loop_two_fb_div_in,
  input  wire logic  loop_one_pump_idle_in,
  input  wire logic  loop_two_pump_idle_in,
  output logic       shared_status_pin_out,
  output logic       shared_status_pin_oe_out,
  output logic       loop_one_polarity_out,
  output logic       loop_two_polarity_out,
  output logic       loop_one_pump_high_out,
  output logic       loop_two_pump_high_out,
  output logic       loop_one_pump_hiz_out,
  output logic       loop_two_pump_hiz_out,
  output logic       loop_one_prescale_128_out,
  output logic       loop_two_prescale_128_out,
  output logic       loop_one_powered_down_out,
  output logic       loop_two_powered_down_out,
  output logic       loop_one_counter_reset_out,
  output logic       loop_two_counter_reset_out,
  output logic       ref_osc_disable_out
);
  localparam int W = synth_mode_pkg::WORD_BITS;
  // ************************************
  // Pin synchronisers
  // ************************************
  logic [2:0] sync_a;
  logic [2:0] sync_b;
  logic       sclk_d;
  logic       le_d;
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      sync_a <= 3'h0;
      sync_b <= 3'h0;
      sclk_d <= 1'b0;
      le_d   <= 1'b0;
    end else begin
      sync_a <= {serial_clock_in, serial_data_in, latch_strobe_in};
      sync_b <= sync_a;
      sclk_d <= sync_b[2];
      le_d   <= sync_b[0];
    end
  end
  logic sclk_rise;
  logic le_rise;
  // Data is taken from the same stage as the clock, so hold time survives the delay
  assign sclk_rise = sync_b[2] && !sclk_d;
  assign le_rise   = sync_b[0] && !le_d;
  // ************************************
  // Shift register
  // ************************************
  logic [W-1:0] shift;
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) shift <= '0;
    else if (sclk_rise) shift <= {shift[W-2:0], sync_b[1]};
  end
  logic [1:0] wsel;
  assign wsel = shift[1:0];
  logic [4:0] ref_word;
  logic [1:0] fb_word;
  assign ref_word = shift[synth_mode_pkg::POS_STATSEL-1:synth_mode_pkg::POS_POLARITY-1];
  assign fb_word  = shift[synth_mode_pkg::POS_PWDN-1:synth_mode_pkg::POS_PRESCALE-1];
  // ************************************
  // Loop controllers
  // ************************************
  logic [4:0] one_ref;
  logic [4:0] two_ref;
  logic [1:0] one_fb;
  logic [1:0] two_fb;
  logic       one_pd;
  logic       two_pd;
  loop_mode_ctrl #(.REF_SEL(synth_mode_pkg::SEL_ONE_REF), .FB_SEL(synth_mode_pkg::SEL_ONE_FB)) u_one (
    .core_clk_in      (core_clk_in),
    .rst_n_in         (rst_n_in),
    .latch_in         (le_rise),
    .word_select_in   (wsel),
    .ref_bits_in      (ref_word),
    .fb_bits_in       (fb_word),
    .pump_idle_in     (loop_one_pump_idle_in),
    .ref_bits_out     (one_ref),
    .fb_bits_out      (one_fb),
    .powered_down_out (one_pd)
  );
  loop_mode_ctrl #(.REF_SEL(synth_mode_pkg::SEL_TWO_REF), .FB_SEL(synth_mode_pkg::SEL_TWO_FB)) u_two (
    .core_clk_in      (core_clk_in),
    .rst_n_in         (rst_n_in),
    .latch_in         (le_rise),
    .word_select_in   (wsel),
    .ref_bits_in      (ref_word),
    .fb_bits_in       (fb_word),
    .pump_idle_in     (loop_two_pump_idle_in),
    .ref_bits_out     (two_ref),
    .fb_bits_out      (two_fb),
    .powered_down_out (two_pd)
  );
  // ************************************
  // Status pin select
  // ************************************
  logic [1:0] lock_select;
  logic [1:0] status_select;
  assign lock_select   = {one_ref[3], two_ref[3]};
  assign status_select = {one_ref[4], two_ref[4]};
  logic next_pin;
  logic next_oe;
  logic next_rst_one;
  logic next_rst_two;
  always_comb begin
    next_pin     = 1'b0;
    next_oe      = 1'b1;
    next_rst_one = 1'b0;
    next_rst_two = 1'b0;
    unique case (status_select)
      2'h0: begin
        unique case (lock_select)
          2'h0: next_pin = 1'b0;
          2'h1: next_pin = loop_two_locked_in;
          2'h2: next_pin = loop_one_locked_in;
          2'h3: next_pin = loop_one_locked_in && loop_two_locked_in;
        endcase
      end
      2'h1: next_pin = lock_select[0] ? loop_two_fb_div_in : loop_two_ref_div_in;
      2'h2: next_pin = lock_select[0] ? loop_one_fb_div_in : loop_one_ref_div_in;
      2'h3: begin
        if (lock_select == 2'h0) begin
          // Open drain: pulls low while fast lock is on, released otherwise
          next_pin = 1'b0;
          next_oe  = one_ref[1];
        end else begin
          next_rst_one = lock_select[1];
          next_rst_two = lock_select[0];
        end
      end
    endcase
  end
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      shared_status_pin_out      <= 1'b0;
      shared_status_pin_oe_out   <= 1'b1;
      loop_one_counter_reset_out <= 1'b0;
      loop_two_counter_reset_out <= 1'b0;
    end else begin
      shared_status_pin_out      <= next_pin;
      shared_status_pin_oe_out   <= next_oe;
      // Counters restart from the same reset release, keeping R and N aligned
      loop_one_counter_reset_out <= next_rst_one || one_pd;
      loop_two_counter_reset_out <= next_rst_two || two_pd;
    end
  end
  // ************************************
  // Loop mode outputs
  // ************************************
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      loop_one_polarity_out  <= 1'b0;
      loop_two_polarity_out  <= 1'b0;
      loop_one_pump_high_out <= 1'b0;
      loop_two_pump_high_out <= 1'b0;
    end else begin
      loop_one_polarity_out  <= one_ref[0];
      loop_two_polarity_out  <= two_ref[0];
      loop_one_pump_high_out <= one_ref[1];
      loop_two_pump_high_out <= two_ref[1];
    end
  end
  // Pumps parked in high impedance through reset; afterwards only bit 2, a counter reset or powerdown parks them
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      loop_one_pump_hiz_out <= 1'b1;
      loop_two_pump_hiz_out <= 1'b1;
    end else begin
      loop_one_pump_hiz_out <= one_ref[2] || next_rst_one || one_pd;
      loop_two_pump_hiz_out <= two_ref[2] || next_rst_two || two_pd;
    end
  end
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      loop_one_prescale_128_out <= 1'b0;
      loop_two_prescale_128_out <= 1'b0;
    end else begin
      loop_one_prescale_128_out <= one_fb[0];
      loop_two_prescale_128_out <= two_fb[0];
    end
  end
  // ************************************
  // Powerdown outputs
  // ************************************
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      loop_one_powered_down_out <= 1'b0;
      loop_two_powered_down_out <= 1'b0;
    end else begin
      loop_one_powered_down_out <= one_pd;
      loop_two_powered_down_out <= two_pd;
    end
  end
  // Follows latched bits, so it stops even while a synchronous loop still waits
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) ref_osc_disable_out <= 1'b0;
    else ref_osc_disable_out <= one_fb[1] && two_fb[1];
  end
  // ************************************
  // Checks
  // ************************************
  chk_pin_disabled: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    status_select == 2'h0 && lock_select == 2'h0 |=> !shared_status_pin_out && shared_status_pin_oe_out)
    else $error("status pin not low");
  chk_both_lock: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    status_select == 2'h0 && lock_select == 2'h3 |=> shared_status_pin_out == $past(loop_one_locked_in && loop_two_locked_in))
    else $error("combined lock wrong");
  chk_fast_lock: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    status_select == 2'h3 && lock_select == 2'h0 |=> shared_status_pin_oe_out == $past(one_ref[1]))
    else $error("fast lock drive wrong");
  chk_reset_hiz: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    next_rst_two |=> loop_two_counter_reset_out && loop_two_pump_hiz_out)
    else $error("counter reset wrong");
  chk_osc_off: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    ref_osc_disable_out |-> $past(one_fb[1]) && $past(two_fb[1]))
    else $error("oscillator off early");
  chk_shift_in: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    sclk_rise |=> shift[0] == $past(sync_b[1]))
    else $error("shift bit lost");
  // ************************************
  // Latch checks
  // ************************************
  chk_latch_ref: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    le_rise && wsel == synth_mode_pkg::SEL_ONE_REF |=> one_ref == $past(ref_word))
    else $error("reference word lost");
  chk_latch_fb: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    le_rise && wsel == synth_mode_pkg::SEL_TWO_FB |=> two_fb == $past(fb_word))
    else $error("feedback word lost");
  chk_latch_other: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    le_rise && wsel == synth_mode_pkg::SEL_TWO_REF |=> one_ref == $past(one_ref) && one_fb == $past(one_fb))
    else $error("wrong latch written");
  chk_mode_bits: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    1'b1 |=> {loop_one_polarity_out, loop_one_pump_high_out} == $past({one_ref[0], one_ref[1]}))
    else $error("loop one mode bits wrong");
  chk_mode_bits_two: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    1'b1 |=> {loop_two_polarity_out, loop_two_pump_high_out} == $past({two_ref[0], two_ref[1]}))
    else $error("loop two mode bits wrong");
  chk_prescale: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    1'b1 |=> {loop_one_prescale_128_out, loop_two_prescale_128_out} == $past({one_fb[0], two_fb[0]}))
    else $error("prescaler select wrong");
  chk_hiz_bit: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    one_ref[2] |=> loop_one_pump_hiz_out)
    else $error("loop one pump not parked");
  chk_hiz_bit_two: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    two_ref[2] |=> loop_two_pump_hiz_out)
    else $error("loop two pump not parked");
  // ************************************
  // Status pin checks
  // ************************************
  chk_lock_two: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    status_select == 2'h0 && lock_select == 2'h1 |=> shared_status_pin_out == $past(loop_two_locked_in))
    else $error("loop two lock wrong");
  chk_lock_one: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    status_select == 2'h0 && lock_select == 2'h2 |=> shared_status_pin_out == $past(loop_one_locked_in))
    else $error("loop one lock wrong");
  chk_ref_route: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    status_select == 2'h1 && !lock_select[0] |=> shared_status_pin_out == $past(loop_two_ref_div_in))
    else $error("loop two reference route wrong");
  chk_ref_route_one: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    status_select == 2'h2 && !lock_select[0] |=> shared_status_pin_out == $past(loop_one_ref_div_in))
    else $error("loop one reference route wrong");
  chk_fb_route: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    status_select == 2'h2 && lock_select[0] |=> shared_status_pin_out == $past(loop_one_fb_div_in))
    else $error("loop one feedback route wrong");
  chk_fb_route_two: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    status_select == 2'h1 && lock_select[0] |=> shared_status_pin_out == $past(loop_two_fb_div_in))
    else $error("loop two feedback route wrong");
  chk_route_drive: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    status_select != 2'h3 |=> shared_status_pin_oe_out)
    else $error("status pin not driven");
  chk_fast_low: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    status_select == 2'h3 && lock_select == 2'h0 |=> !shared_status_pin_out)
    else $error("fast lock level wrong");
  chk_reset_one: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    status_select == 2'h3 && lock_select[1] |=> loop_one_counter_reset_out && loop_one_pump_hiz_out)
    else $error("loop one counter reset wrong");
  // ************************************
  // Powerdown checks
  // ************************************
  chk_pd_hiz: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    one_pd |=> loop_one_counter_reset_out && loop_one_pump_hiz_out && loop_one_powered_down_out)
    else $error("loop one powerdown incomplete");
  chk_pd_hiz_two: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    two_pd |=> loop_two_counter_reset_out && loop_two_pump_hiz_out && loop_two_powered_down_out)
    else $error("loop two powerdown incomplete");
  chk_osc_on: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    !one_fb[1] || !two_fb[1] |=> !ref_osc_disable_out)
    else $error("oscillator stopped early");
  cov_fast: cover property (@(posedge core_clk_in) disable iff (!rst_n_in)
    status_select == 2'h3 && lock_select == 2'h0 && one_ref[1]);
  cov_pd: cover property (@(posedge core_clk_in) disable iff (!rst_n_in) one_pd && two_pd);
  cov_lock: cover property (@(posedge core_clk_in) disable iff (!rst_n_in)
    status_select == 2'h0 && lock_select == 2'h3 && shared_status_pin_out);
  cov_sync_wait: cover property (@(posedge core_clk_in) disable iff (!rst_n_in)
    two_fb[1] && !two_pd && !two_ref[2]);
  cov_count_reset: cover property (@(posedge core_clk_in) disable iff (!rst_n_in)
    status_select == 2'h3 && lock_select == 2'h3);
endmodule : dual_synth_mode_powerdown_ctrl
`default_nettype wire

// ---- verilog/synth_mode_pkg.sv ----
// Package of constants for the dual synthesizer mode and powerdown control
package synth_mode_pkg;
  localparam int          WORD_BITS    = 22;
  localparam int          POS_POLARITY = 18;
  localparam int          POS_CURRENT  = 19;
  localparam int          POS_HIZ      = 20;
  localparam int          POS_LOCKSEL  = 21;
  localparam int          POS_STATSEL  = 22;
  localparam int          POS_PRESCALE = 21;
  localparam int          POS_PWDN     = 22;
  localparam logic [1:0]  SEL_TWO_REF  = 2'h0;
  localparam logic [1:0]  SEL_ONE_REF  = 2'h1;
  localparam logic [1:0]  SEL_TWO_FB   = 2'h2;
  localparam logic [1:0]  SEL_ONE_FB   = 2'h3;
  localparam logic [4:0]  REF_RESET    = 5'h00;
  localparam logic [1:0]  FB_RESET     = 2'h0;
endpackage : synth_mode_pkg

// ---- verilog/loop_mode_ctrl.sv ----
// One loop's mode latches and powerdown sequencer
`timescale 1ns/1ps
`default_nettype none
module loop_mode_ctrl #(
  parameter logic [1:0] REF_SEL = 2'h0,
  parameter logic [1:0] FB_SEL  = 2'h2
) (
  input  wire logic        core_clk_in,
  input  wire logic        rst_n_in,
  input  wire logic        latch_in,
  input  wire logic [1:0]  word_select_in,
  input  wire logic [4:0]  ref_bits_in,
  input  wire logic [1:0]  fb_bits_in,
  input  wire logic        pump_idle_in,
  output logic      [4:0]  ref_bits_out,
  output logic      [1:0]  fb_bits_out,
  output logic             powered_down_out
);
  // ************************************
  // Latches
  // ************************************
  typedef enum logic [1:0] {PD_ACTIVE = 2'b00, PD_WAIT = 2'b01, PD_DOWN = 2'b11} pd_state_t;
  pd_state_t state;
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      ref_bits_out <= synth_mode_pkg::REF_RESET;
      fb_bits_out  <= synth_mode_pkg::FB_RESET;
    end else if (latch_in) begin
      if (word_select_in == REF_SEL) ref_bits_out <= ref_bits_in;
      if (word_select_in == FB_SEL) fb_bits_out <= fb_bits_in;
    end
  end
  // ************************************
  // Powerdown sequencer
  // ************************************
  logic fb_latch;
  assign fb_latch = latch_in && (word_select_in == FB_SEL);
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      state <= PD_ACTIVE;
    end else if (fb_latch && !fb_bits_in[1]) begin
      state <= PD_ACTIVE;
    end else if (fb_latch && fb_bits_in[1] && state == PD_ACTIVE) begin
      state <= ref_bits_out[2] ? PD_DOWN : PD_WAIT;
    end else if (state == PD_WAIT && pump_idle_in) begin
      state <= PD_DOWN;
    end
  end
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) powered_down_out <= 1'b0;
    else powered_down_out <= (state == PD_DOWN);
  end
  chk_async_down: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    fb_latch && fb_bits_in[1] && ref_bits_out[2] && state == PD_ACTIVE |-> ##2 powered_down_out)
    else $error("async powerdown late");
  chk_power_up: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    fb_latch && !fb_bits_in[1] |-> ##2 !powered_down_out)
    else $error("power up late");
  chk_sync_wait: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    state == PD_WAIT && !pump_idle_in && !latch_in |=> state == PD_WAIT)
    else $error("sync powerdown early");
endmodule : loop_mode_ctrl
`default_nettype wire

// ---- verif/serial_host_model.sv ----
// Host model driving the three-wire serial programming port
`timescale 1ns/1ps
`default_nettype none
module serial_host_model (
  input  wire logic core_clk_in,
  output logic      serial_clock_out,
  output logic      serial_data_out,
  output logic      latch_strobe_out
);
  // ****************************************
  // Word transfer
  // ****************************************
  initial begin
    serial_clock_out = 1'b0;
    serial_data_out  = 1'b0;
    latch_strobe_out = 1'b0;
  end
  // Clock stands low between frames; 8 core cycles a bit gives 200 ns
  task automatic send_word(input logic [synth_mode_pkg::WORD_BITS-1:0] word);
    @(negedge core_clk_in);
    for (int i = synth_mode_pkg::WORD_BITS - 1; i >= 0; i--) begin
      serial_data_out = word[i];
      repeat (4) @(negedge core_clk_in);
      serial_clock_out = 1'b1;
      repeat (4) @(negedge core_clk_in);
      serial_clock_out = 1'b0;
    end
    // Released data shows the inverse, so a stale level is never mistaken
    serial_data_out = ~word[0];
    repeat (4) @(negedge core_clk_in);
    latch_strobe_out = 1'b1;
    repeat (4) @(negedge core_clk_in);
    latch_strobe_out = 1'b0;
  endtask : send_word
endmodule : serial_host_model
`default_nettype wire

// ---- verif/dual_synth_mode_powerdown_ctrl_tb_top.sv ----
// Self-checking bench for the dual synthesizer mode and powerdown control
`timescale 1ns/1ps
`default_nettype none
module dual_synth_mode_powerdown_ctrl_tb_top;
  logic clk, rst_n, sclk, sdata, latch, pin, pin_oe, osc_off;
  logic one_lock, two_lock, one_rdiv, two_rdiv, one_fdiv, two_fdiv, one_idle, two_idle;
  logic one_pol, two_pol, one_cur, two_cur, one_hiz, two_hiz, one_p128, two_p128;
  logic one_pd, two_pd, one_crst, two_crst;
  int   error_cnt = 0;
  int   tests_run = 0;
  int   cycles    = 0;
  // ****************************************
  // Harness
  // ****************************************
  serial_host_model host (.core_clk_in(clk), .serial_clock_out(sclk), .serial_data_out(sdata),
    .latch_strobe_out(latch));
  dual_synth_mode_powerdown_ctrl dut (.core_clk_in(clk), .rst_n_in(rst_n), .serial_clock_in(sclk),
    .serial_data_in(sdata), .latch_strobe_in(latch), .loop_one_locked_in(one_lock),
    .loop_two_locked_in(two_lock), .loop_one_ref_div_in(one_rdiv), .loop_two_ref_div_in(two_rdiv),
    .loop_one_fb_div_in(one_fdiv), .loop_two_fb_div_in(two_fdiv), .loop_one_pump_idle_in(one_idle),
    .loop_two_pump_idle_in(two_idle), .shared_status_pin_out(pin), .shared_status_pin_oe_out(pin_oe),
    .loop_one_polarity_out(one_pol), .loop_two_polarity_out(two_pol), .loop_one_pump_high_out(one_cur),
    .loop_two_pump_high_out(two_cur), .loop_one_pump_hiz_out(one_hiz), .loop_two_pump_hiz_out(two_hiz),
    .loop_one_prescale_128_out(one_p128), .loop_two_prescale_128_out(two_p128),
    .loop_one_powered_down_out(one_pd), .loop_two_powered_down_out(two_pd),
    .loop_one_counter_reset_out(one_crst), .loop_two_counter_reset_out(two_crst),
    .ref_osc_disable_out(osc_off));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // Whole run needs about 8000 cycles
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 15000) begin
      error_cnt++;
      give_verdict();
    end
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check
  function automatic logic [21:0] rw(logic [1:0] sel, logic [4:0] m);
    rw = {m, 15'h2AD5, sel};
  endfunction : rw
  function automatic logic [21:0] fw(logic [1:0] sel, logic pwdn, logic pre);
    fw = {pwdn, pre, 18'h2B4C1, sel};
  endfunction : fw
  task automatic send(input logic [21:0] w);
    host.send_word(w);
    repeat (10) @(negedge clk);
  endtask : send
  // Lock bits {one,two}, status bits {one,two}
  task automatic set_modes(input logic [1:0] ld, input logic [1:0] fo, input logic cur);
    send(rw(synth_mode_pkg::SEL_ONE_REF, {fo[1], ld[1], 1'b0, cur, 1'b1}));
    send(rw(synth_mode_pkg::SEL_TWO_REF, {fo[0], ld[0], 1'b0, 1'b0, 1'b1}));
  endtask : set_modes
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_modes();
    logic a;
    for (int k = 0; k < 2; k++) begin
      a = (k == 0);
      send(rw(synth_mode_pkg::SEL_ONE_REF, {2'b00, ~a, a, a}));
      send(rw(synth_mode_pkg::SEL_TWO_REF, {2'b00, a, ~a, ~a}));
      send(fw(synth_mode_pkg::SEL_ONE_FB, 1'b0, a));
      send(fw(synth_mode_pkg::SEL_TWO_FB, 1'b0, ~a));
      check({one_pol, two_pol, one_cur, two_cur, one_hiz, two_hiz, one_p128, two_p128},
        {a, ~a, a, ~a, ~a, a, a, ~a});
      check({pin_oe, pin, one_pd, two_pd}, 8'h08);
    end
  endtask : t_modes
  task automatic t_lock();
    logic e;
    for (int c = 0; c < 4; c++) begin
      set_modes(c[1:0], 2'b00, 1'b0);
      for (int l = 0; l < 4; l++) begin
        {one_lock, two_lock} = l[1:0];
        e = (c == 1) ? two_lock : (c == 2) ? one_lock : (c == 3) ? (one_lock & two_lock) : 1'b0;
        repeat (4) @(negedge clk);
        check({pin_oe, pin}, {1'b1, e});
      end
    end
  endtask : t_lock
  task automatic t_div();
    for (int c = 0; c < 4; c++) begin
      set_modes({c[0], c[1]}, c[0] ? 2'b10 : 2'b01, 1'b0);
      for (int v = 0; v < 2; v++) begin
        one_rdiv = v[0] ^ (c != 1);
        two_rdiv = v[0] ^ (c != 0);
        one_fdiv = v[0] ^ (c != 3);
        two_fdiv = v[0] ^ (c != 2);
        repeat (4) @(negedge clk);
        check({pin_oe, pin}, {1'b1, v[0]});
      end
    end
  endtask : t_div
  task automatic t_reset_modes();
    for (int k = 0; k < 2; k++) begin
      set_modes(2'b00, 2'b11, k[0]);
      check({pin_oe, pin, one_crst, two_crst}, {k[0], 3'b000});
    end
    for (int c = 1; c < 4; c++) begin
      set_modes(c[1:0], 2'b11, 1'b0);
      check({one_crst, two_crst, one_hiz, two_hiz}, {c[1], c[0], c[1], c[0]});
    end
  endtask : t_reset_modes
  task automatic t_pwdn();
    send(rw(synth_mode_pkg::SEL_ONE_REF, 5'h05));
    send(rw(synth_mode_pkg::SEL_TWO_REF, 5'h01));
    send(fw(synth_mode_pkg::SEL_ONE_FB, 1'b1, 1'b0));
    check({one_pd, two_pd, osc_off, one_crst}, 8'h09);
    send(fw(synth_mode_pkg::SEL_TWO_FB, 1'b1, 1'b0));
    check({two_pd, osc_off}, 8'h01);
    two_idle = 1'b1;
    repeat (5) @(negedge clk);
    check({two_pd, osc_off, two_crst}, 8'h07);
    send(rw(synth_mode_pkg::SEL_ONE_REF, 5'h04));
    check({one_pol, one_pd}, 8'h01);
    send(fw(synth_mode_pkg::SEL_ONE_FB, 1'b0, 1'b0));
    check({one_pd, osc_off}, 8'h00);
    send(fw(synth_mode_pkg::SEL_TWO_FB, 1'b0, 1'b0));
    check(two_pd, 1'b0);
  endtask : t_pwdn
  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : give_verdict
  initial begin
    rst_n = 1'b0;
    {one_lock, two_lock, one_rdiv, two_rdiv, one_fdiv, two_fdiv, one_idle, two_idle} = 8'h00;
    repeat (10) @(negedge clk);
    check({one_hiz, two_hiz, pin_oe, pin, one_pd, two_pd, osc_off, one_crst}, 8'hE0);
    rst_n = 1'b1;
    @(negedge clk);
    check({pin_oe, pin}, 8'h02);
    t_modes();
    t_lock();
    t_div();
    t_reset_modes();
    t_pwdn();
    give_verdict();
  end
endmodule : dual_synth_mode_powerdown_ctrl_tb_top
`default_nettype wire
